// ==== hdl/pamx_pkg.sv ====
// package: constants, function tables and state layout of the port alternate function mux
package pamx_pkg;

	// ==========================================================
	// sizes
	localparam int PA_PINS = 6;
	localparam int PC_PINS = 8;
	localparam int FN_W = 5;
	localparam int AW = 14;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int STAT_PC_LSB = 8;

	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_ADDR_A = 12'hfd0;
	localparam logic [11:0] IDX_CTL_A = 12'hfd1;
	localparam logic [11:0] IDX_ADDR_B = 12'hfd4;
	localparam logic [11:0] IDX_CTL_B = 12'hfd5;
	localparam logic [11:0] IDX_ADDR_C = 12'hfd8;
	localparam logic [11:0] IDX_CTL_C = 12'hfd9;
	localparam logic [11:0] IDX_INT_STAT = 12'hfe0;
	localparam logic [11:0] IDX_INT_EN = 12'hfe1;
	localparam logic [11:0] IDX_INT_CLR = 12'hfe2;
	localparam logic [11:0] IDX_EDGE_POL = 12'hfe3;
	localparam logic [AW-1:0] BA_ADDR_A = {IDX_ADDR_A, 2'h0};
	localparam logic [AW-1:0] BA_CTL_A = {IDX_CTL_A, 2'h0};
	localparam logic [AW-1:0] BA_ADDR_B = {IDX_ADDR_B, 2'h0};
	localparam logic [AW-1:0] BA_CTL_B = {IDX_CTL_B, 2'h0};
	localparam logic [AW-1:0] BA_ADDR_C = {IDX_ADDR_C, 2'h0};
	localparam logic [AW-1:0] BA_CTL_C = {IDX_CTL_C, 2'h0};
	localparam logic [AW-1:0] BA_INT_STAT = {IDX_INT_STAT, 2'h0};
	localparam logic [AW-1:0] BA_INT_EN = {IDX_INT_EN, 2'h0};
	localparam logic [AW-1:0] BA_INT_CLR = {IDX_INT_CLR, 2'h0};
	localparam logic [AW-1:0] BA_EDGE_POL = {IDX_EDGE_POL, 2'h0};

	// ==========================================================
	// sub-register selectors and reset values
	localparam logic [7:0] SUB_AF = 8'h02;
	localparam logic [7:0] SUB_SEL1 = 8'h07;
	localparam logic [7:0] SUB_SEL2 = 8'h08;
	localparam logic [7:0] RST_PORT_ADDR = 8'h00;
	localparam logic [7:0] RST_AF_A = 8'h04;
	localparam logic [7:0] RST_AF = 8'h00;
	localparam logic [7:0] RST_SEL = 8'h00;
	localparam logic [7:0] RST_EDGE_POL = 8'h00;
	localparam logic [15:0] RST_INT = 16'h0000;

	// ==========================================================
	// pin function codes
	localparam logic [FN_W-1:0] FN_GPIO = 5'h00;
	localparam logic [FN_W-1:0] FN_RSVD = 5'h01;
	localparam logic [FN_W-1:0] FN_TIMER_ZERO_INPUT = 5'h02;
	localparam logic [FN_W-1:0] FN_TIMER_ZERO_OUTPUT_INV = 5'h03;
	localparam logic [FN_W-1:0] FN_TIMER_ZERO_OUTPUT = 5'h04;
	localparam logic [FN_W-1:0] FN_EXTERNAL_CLOCK_INPUT = 5'h05;
	localparam logic [FN_W-1:0] FN_ANALOG = 5'h06;
	localparam logic [FN_W-1:0] FN_SERIAL_DRIVER_ENABLE = 5'h07;
	localparam logic [FN_W-1:0] FN_EXTERNAL_RESET = 5'h08;
	localparam logic [FN_W-1:0] FN_TIMER_ONE_OUTPUT = 5'h09;
	localparam logic [FN_W-1:0] FN_SERIAL_CLEAR_TO_SEND = 5'h0a;
	localparam logic [FN_W-1:0] FN_COMPARATOR_RESULT_OUT = 5'h0b;
	localparam logic [FN_W-1:0] FN_TIMER_ONE_INPUT = 5'h0c;
	localparam logic [FN_W-1:0] FN_SERIAL_RECEIVE_DATA = 5'h0d;
	localparam logic [FN_W-1:0] FN_SERIAL_TRANSMIT_DATA = 5'h0e;
	localparam logic [FN_W-1:0] FN_TIMER_ONE_OUTPUT_INV = 5'h0f;
	localparam logic [FN_W-1:0] FN_ANALOG_OR_LED = 5'h10;
	localparam logic [FN_W-1:0] FN_LED_SINK = 5'h11;

	// ==========================================================
	// port A map, inner index is {first, second}
	localparam logic [PA_PINS-1:0][3:0][FN_W-1:0] PA_MAP = '{
		0: '{0: FN_TIMER_ZERO_INPUT, 1: FN_RSVD, 2: FN_RSVD, 3: FN_TIMER_ZERO_OUTPUT_INV}, // R07
		1: '{0: FN_TIMER_ZERO_OUTPUT, 1: FN_RSVD, 2: FN_EXTERNAL_CLOCK_INPUT, 3: FN_ANALOG}, // R08
		2: '{0: FN_SERIAL_DRIVER_ENABLE, 1: FN_EXTERNAL_RESET, 2: FN_TIMER_ONE_OUTPUT,
			3: FN_RSVD}, // R09
		3: '{0: FN_SERIAL_CLEAR_TO_SEND, 1: FN_COMPARATOR_RESULT_OUT, 2: FN_TIMER_ONE_INPUT,
			3: FN_ANALOG}, // R10
		4: '{0: FN_SERIAL_RECEIVE_DATA, 1: FN_RSVD, 2: FN_RSVD, 3: FN_ANALOG}, // R11
		5: '{0: FN_SERIAL_TRANSMIT_DATA, 1: FN_TIMER_ONE_OUTPUT_INV, 2: FN_RSVD,
			3: FN_ANALOG} // R12
	};
	// port C map, inner index is the first set-select bit only
	localparam logic [PC_PINS-1:0][1:0][FN_W-1:0] PC_MAP = '{
		0: '{0: FN_RSVD, 1: FN_ANALOG_OR_LED}, // R01
		1: '{0: FN_RSVD, 1: FN_ANALOG_OR_LED}, // R01
		2: '{0: FN_RSVD, 1: FN_ANALOG_OR_LED}, // R02
		3: '{0: FN_COMPARATOR_RESULT_OUT, 1: FN_LED_SINK}, // R03
		default: '{0: FN_RSVD, 1: FN_LED_SINK} // R03
	};

	// ==========================================================
	// state of the top module
	typedef struct packed {
		logic [2:0][7:0] port_addr;
		logic [2:0][7:0] af;
		logic [2:0][7:0] sel1;
		logic [2:0][7:0] sel2;
		logic [7:0] edge_pol;
		logic [15:0] int_en;
		logic [15:0] int_stat;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irq;
		logic [PA_PINS-1:0][FN_W-1:0] pa_func;
		logic [PC_PINS-1:0][FN_W-1:0] pc_func;
		logic [PC_PINS-1:0] led_en;
	} pamx_state_s;

endpackage

// ==== hdl/pamx_edge.sv ====
// module: per-pin edge detector raising one-cycle interrupt events
`timescale 1ns/1ps
module pamx_edge #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin,
	input wire logic [W-1:0] any_edge,
	input wire logic [W-1:0] rise_sel,
	output logic [W-1:0] evt
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic armed;
	} pamx_edge_s;

	pamx_edge_s st_reg;
	pamx_edge_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.prev = pin;
		st_next.armed = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// edge qualification; nothing fires until one sample is held
	for (genvar i = 0; i < W; i++) begin : g_pin
		assign evt[i] = !st_reg.armed ? 1'b0 :
			any_edge[i] ? (pin[i] ^ st_reg.prev[i]) : // R14
			rise_sel[i] ? (pin[i] & ~st_reg.prev[i]) : // R13
			(~pin[i] & st_reg.prev[i]); // R13
	end
endmodule

// ==== hdl/pamx_top.sv ====
// module: port alternate function mux with APB sub-register access and pin interrupts
//
// What this block does
// R01: port C pins 0 and 1 select analog input or LED drive when first bit set.
// R02: port C pin 2 selects analog input or LED drive when first bit set.
// R03: port C pin 3 comparator out at 0, LED at 1; pins 4-7 LED at 1.
// R04: port C second set-select is stored and readable but selects nothing.
// R05: port B second set-select is stored and readable but selects nothing.
// R06: a pin takes its selected function only while its enable bit is set.
// R07: port A pin 0: timer zero input at 00, inverted output at 11.
// R08: port A pin 1: timer output, reserved, external clock, analog.
// R09: port A pin 2: driver enable, external reset, timer one out, reserved.
// R10: port A pin 3: clear to send, comparator out, timer one in, analog.
// R11: port A pin 4: receive data at 00, analog input at 11.
// R12: port A pin 5: transmit data, inverted timer one, reserved, analog.
// R13: some pins interrupt on one selectable edge, rising or falling.
// R14: other pins interrupt on every edge of the pin.
// R15: selector 02h reaches the enable sub-register through the control register.
// R16: selectors 07h and 08h reach the first and second set-select registers.
`timescale 1ns/1ps
module pamx_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pamx_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pamx_pkg::PA_PINS-1:0] pa_pin,
	input wire logic [pamx_pkg::PC_PINS-1:0] pc_pin,
	output logic [pamx_pkg::PA_PINS-1:0][pamx_pkg::FN_W-1:0] pa_func,
	output logic [pamx_pkg::PC_PINS-1:0][pamx_pkg::FN_W-1:0] pc_func,
	output logic [pamx_pkg::PC_PINS-1:0] pc_led_en,
	output logic irq
);
	pamx_pkg::pamx_state_s st_reg;
	pamx_pkg::pamx_state_s st_next;
	logic [pamx_pkg::PA_PINS-1:0] pa_evt;
	logic [pamx_pkg::PC_PINS-1:0] pc_evt;
	logic [15:0] evt;

	// ==========================================================
	// pin interrupt sources
	pamx_edge #(
		.W(pamx_pkg::PA_PINS)
	) u_edge_a (
		.clk(clk),
		.rst(rst),
		.pin(pa_pin),
		.any_edge('0),
		.rise_sel(st_reg.edge_pol[pamx_pkg::PA_PINS-1:0]),
		.evt(pa_evt)
	);

	pamx_edge #(
		.W(pamx_pkg::PC_PINS)
	) u_edge_c (
		.clk(clk),
		.rst(rst),
		.pin(pc_pin),
		.any_edge('1),
		.rise_sel('0),
		.evt(pc_evt)
	);

	assign evt = {pc_evt, 2'h0, pa_evt};

	// ==========================================================
	// next state: bus decode, sub-registers, status, pin functions
	always_comb begin
		logic setup;
		logic done;
		logic hit;
		logic is_addr;
		logic is_ctl;
		logic [1:0] port;
		logic [7:0] sub_rd;
		logic [31:0] rd;
		logic [15:0] clr;
		setup = psel & ~penable;
		done = psel & penable & st_reg.ready;
		hit = 1'b1;
		is_addr = 1'b0;
		is_ctl = 1'b0;
		port = 2'h0;
		sub_rd = 8'h00;
		rd = 32'h00000000;
		clr = 16'h0000;
		st_next = st_reg;

		case (paddr)
			pamx_pkg::BA_ADDR_A: begin
				is_addr = 1'b1;
				port = 2'(pamx_pkg::PORT_A);
			end
			pamx_pkg::BA_CTL_A: begin
				is_ctl = 1'b1;
				port = 2'(pamx_pkg::PORT_A);
			end
			pamx_pkg::BA_ADDR_B: begin
				is_addr = 1'b1;
				port = 2'(pamx_pkg::PORT_B);
			end
			pamx_pkg::BA_CTL_B: begin
				is_ctl = 1'b1;
				port = 2'(pamx_pkg::PORT_B);
			end
			pamx_pkg::BA_ADDR_C: begin
				is_addr = 1'b1;
				port = 2'(pamx_pkg::PORT_C);
			end
			pamx_pkg::BA_CTL_C: begin
				is_ctl = 1'b1;
				port = 2'(pamx_pkg::PORT_C);
			end
			pamx_pkg::BA_INT_STAT: begin
				rd = {16'h0000, st_reg.int_stat};
			end
			pamx_pkg::BA_INT_EN: begin
				rd = {16'h0000, st_reg.int_en};
			end
			pamx_pkg::BA_INT_CLR: begin
				rd = 32'h00000000;
			end
			pamx_pkg::BA_EDGE_POL: begin
				rd = {24'h000000, st_reg.edge_pol};
			end
			default: begin
				hit = 1'b0;
			end
		endcase

		// control register window onto the selected sub-register
		case (st_reg.port_addr[port])
			pamx_pkg::SUB_AF: sub_rd = st_reg.af[port]; // R15
			pamx_pkg::SUB_SEL1: sub_rd = st_reg.sel1[port]; // R16
			pamx_pkg::SUB_SEL2: sub_rd = st_reg.sel2[port]; // R04 R05 R16
			default: sub_rd = 8'h00;
		endcase
		if (is_addr) begin
			rd = {24'h000000, st_reg.port_addr[port]};
		end
		if (is_ctl) begin
			rd = {24'h000000, sub_rd};
		end

		// read data and answer are registered in the setup cycle
		st_next.ready = setup;
		st_next.slverr = setup & ~hit;
		if (setup) begin
			st_next.rdata = rd;
		end

		if (done && pwrite && hit) begin
			if (is_addr) begin
				st_next.port_addr[port] = pwdata[7:0];
			end
			if (is_ctl) begin
				case (st_reg.port_addr[port])
					pamx_pkg::SUB_AF: st_next.af[port] = pwdata[7:0]; // R15
					pamx_pkg::SUB_SEL1: st_next.sel1[port] = pwdata[7:0]; // R16
					pamx_pkg::SUB_SEL2: st_next.sel2[port] = pwdata[7:0]; // R04 R05 R16
					default: st_next.sel2[port] = st_reg.sel2[port];
				endcase
			end
			if (paddr == pamx_pkg::BA_INT_EN) begin
				st_next.int_en = pwdata[15:0];
			end
			if (paddr == pamx_pkg::BA_INT_CLR) begin
				clr = pwdata[15:0];
			end
			if (paddr == pamx_pkg::BA_EDGE_POL) begin
				st_next.edge_pol = pwdata[7:0];
			end
		end

		// a new event wins over a clear in the same cycle
		st_next.int_stat = (st_reg.int_stat & ~clr) | evt; // R13 R14
		st_next.irq = |(st_next.int_stat & st_next.int_en);

		// pin functions follow the registered sub-registers one cycle later
		for (int i = 0; i < pamx_pkg::PA_PINS; i++) begin
			if (st_reg.af[pamx_pkg::PORT_A][i]) begin
				st_next.pa_func[i] = pamx_pkg::PA_MAP[i][{st_reg.sel1[pamx_pkg::PORT_A][i],
					st_reg.sel2[pamx_pkg::PORT_A][i]}]; // R06 R07 R08 R09 R10 R11 R12
			end else begin
				st_next.pa_func[i] = pamx_pkg::FN_GPIO; // R06
			end
		end
		// second set-select of port C is left out of the lookup
		for (int i = 0; i < pamx_pkg::PC_PINS; i++) begin
			if (st_reg.af[pamx_pkg::PORT_C][i]) begin
				st_next.pc_func[i] = pamx_pkg::PC_MAP[i][st_reg.sel1[pamx_pkg::PORT_C][i]]; // R01 R02 R03 R04 R06
			end else begin
				st_next.pc_func[i] = pamx_pkg::FN_GPIO; // R06
			end
			st_next.led_en[i] = (st_next.pc_func[i] == pamx_pkg::FN_LED_SINK) ||
				(st_next.pc_func[i] == pamx_pkg::FN_ANALOG_OR_LED);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg.port_addr <= {3{pamx_pkg::RST_PORT_ADDR}};
			st_reg.af <= {pamx_pkg::RST_AF, pamx_pkg::RST_AF, pamx_pkg::RST_AF_A};
			st_reg.sel1 <= {3{pamx_pkg::RST_SEL}};
			st_reg.sel2 <= {3{pamx_pkg::RST_SEL}};
			st_reg.edge_pol <= pamx_pkg::RST_EDGE_POL;
			st_reg.int_en <= pamx_pkg::RST_INT;
			st_reg.int_stat <= pamx_pkg::RST_INT;
			st_reg.rdata <= 32'h00000000;
			st_reg.ready <= 1'b0;
			st_reg.slverr <= 1'b0;
			st_reg.irq <= 1'b0;
			st_reg.pa_func <= '0;
			st_reg.pc_func <= '0;
			st_reg.led_en <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.slverr;
	assign pa_func = st_reg.pa_func;
	assign pc_func = st_reg.pc_func;
	assign pc_led_en = st_reg.led_en;
	assign irq = st_reg.irq;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_sel(int p, logic [7:0] sub);
		st_reg.port_addr[p] == sub;
	endsequence

	sequence s_ctl_wr(logic [pamx_pkg::AW-1:0] ba);
		psel && penable && pready && pwrite && (paddr == ba);
	endsequence

	a_af_store: assert property (s_ctl_wr(pamx_pkg::BA_CTL_C) and s_sel(2, pamx_pkg::SUB_AF)
		|=> st_reg.af[2] == $past(pwdata[7:0])) // R15
		else $error("enable sub-register write lost");

	a_sel1_store: assert property (s_ctl_wr(pamx_pkg::BA_CTL_A) and s_sel(0, pamx_pkg::SUB_SEL1)
		|=> st_reg.sel1[0] == $past(pwdata[7:0])) // R16
		else $error("first set-select write lost");

	a_sel2b_store: assert property (s_ctl_wr(pamx_pkg::BA_CTL_B) and s_sel(1, pamx_pkg::SUB_SEL2)
		|=> st_reg.sel2[1] == $past(pwdata[7:0])) // R05
		else $error("port b second set-select write lost");

	a_sel2_inert: assert property ($stable(st_reg.af[2]) && $stable(st_reg.sel1[2])
		|=> $stable(pc_func)) // R04
		else $error("port c function moved without enable or first select");

	a_af_gate: assert property (!st_reg.af[2][3] && !st_reg.af[0][2]
		|=> pc_func[3] == pamx_pkg::FN_GPIO && pa_func[2] == pamx_pkg::FN_GPIO) // R06
		else $error("function taken without enable");

	a_pc01_map: assert property (st_reg.af[2][1] && st_reg.sel1[2][1]
		|=> pc_func[1] == pamx_pkg::FN_ANALOG_OR_LED && pc_led_en[1]) // R01
		else $error("port c pin 1 analog selection wrong");

	a_pc2_rsvd: assert property (st_reg.af[2][2] && !st_reg.sel1[2][2]
		|=> pc_func[2] == pamx_pkg::FN_RSVD && !pc_led_en[2]) // R02
		else $error("port c pin 2 reserved selection wrong");

	a_pc3_comp: assert property (st_reg.af[2][3] && !st_reg.sel1[2][3]
		|=> pc_func[3] == pamx_pkg::FN_COMPARATOR_RESULT_OUT) // R03
		else $error("port c pin 3 comparator selection wrong");

	a_pa0_inv: assert property (st_reg.af[0][0] && st_reg.sel1[0][0] && st_reg.sel2[0][0]
		|=> pa_func[0] == pamx_pkg::FN_TIMER_ZERO_OUTPUT_INV) // R07
		else $error("port a pin 0 inverted timer selection wrong");

	a_pa1_clk: assert property (st_reg.af[0][1] && st_reg.sel1[0][1] && !st_reg.sel2[0][1]
		|=> pa_func[1] == pamx_pkg::FN_EXTERNAL_CLOCK_INPUT) // R08
		else $error("port a pin 1 clock selection wrong");

	a_pa2_rst: assert property (st_reg.af[0][2] && !st_reg.sel1[0][2] && st_reg.sel2[0][2]
		|=> pa_func[2] == pamx_pkg::FN_EXTERNAL_RESET) // R09
		else $error("port a pin 2 reset selection wrong");

	a_pa3_comp: assert property (st_reg.af[0][3] && !st_reg.sel1[0][3] && st_reg.sel2[0][3]
		|=> pa_func[3] == pamx_pkg::FN_COMPARATOR_RESULT_OUT) // R10
		else $error("port a pin 3 comparator selection wrong");

	a_pa4_mixed: assert property (st_reg.af[0][4] && (st_reg.sel1[0][4] != st_reg.sel2[0][4])
		|=> pa_func[4] == pamx_pkg::FN_RSVD) // R11
		else $error("port a pin 4 mixed selection not reserved");

	a_pa5_inv: assert property (st_reg.af[0][5] && !st_reg.sel1[0][5] && st_reg.sel2[0][5]
		|=> pa_func[5] == pamx_pkg::FN_TIMER_ONE_OUTPUT_INV) // R12
		else $error("port a pin 5 inverted timer selection wrong");

	a_edge_rise: assert property ($rose(pa_pin[0]) && st_reg.edge_pol[0] && !$past(rst)
		|=> st_reg.int_stat[0] ##1 1'b1) // R13
		else $error("rising edge event missed");

	a_edge_quiet: assert property ($rose(pa_pin[1]) && !st_reg.edge_pol[1] && !st_reg.int_stat[1]
		|=> !st_reg.int_stat[1]) // R13
		else $error("falling-edge pin fired on a rise");

	a_edge_any: assert property ($changed(pc_pin[5]) && !$past(rst)
		|=> st_reg.int_stat[pamx_pkg::STAT_PC_LSB+5]) // R14
		else $error("any-edge event missed");

	a_apb_answer: assert property (psel && !penable |=> pready [*1] ##1 !pready)
		else $error("bus answer not one cycle after setup");
endmodule

// ==== tb/pamx_pin_model.sv ====
// pin-side partner: drives port A and port C pin levels synchronous to the clock
`timescale 1ns/1ps
module pamx_pin_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic [pamx_pkg::PA_PINS-1:0] pa_pin,
	output logic [pamx_pkg::PC_PINS-1:0] pc_pin
);
	// ==========================================================
	// levels
	// pins rest low in reset and hold still unless traffic is requested
	always @(posedge clk) begin
		if (rst) begin
			pa_pin <= '0;
			pc_pin <= '0;
		end else if (run) begin
			pa_pin <= 6'($urandom);
			pc_pin <= 8'($urandom);
		end
	end
endmodule

// ==== tb/pamx_top_test.sv ====
// self-checking bench of the port alternate function mux
`timescale 1ns/1ps
module pamx_top_test;
	// ==========================================================
	// signals
	logic clk = 0;
	logic rst, psel, penable, pwrite, pwrite_d, run, irq_on, er;
	logic [pamx_pkg::AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, irq;
	logic [5:0] pa_pin, pv_a, m_pol;
	logic [7:0] pc_pin, pv_c;
	logic [5:0][4:0] pa_func;
	logic [7:0][4:0] pc_func;
	logic [7:0] pc_led_en;
	logic [15:0] m_stat, m_en, ev, ns, v;
	logic [7:0] m_sub [3][3];
	logic [13:0] ba [3] = '{pamx_pkg::BA_ADDR_A, pamx_pkg::BA_ADDR_B, pamx_pkg::BA_ADDR_C};
	logic [13:0] bc [3] = '{pamx_pkg::BA_CTL_A, pamx_pkg::BA_CTL_B, pamx_pkg::BA_CTL_C};
	logic [7:0] sc [3] = '{pamx_pkg::SUB_AF, pamx_pkg::SUB_SEL1, pamx_pkg::SUB_SEL2};
	int num_errors = 0;
	int checks_done = 0;

	always #4 clk = ~clk;

	pamx_top i_pamx_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pa_pin(pa_pin), .pc_pin(pc_pin), .pa_func(pa_func),
		.pc_func(pc_func), .pc_led_en(pc_led_en), .irq(irq));
	pamx_pin_model i_pamx_pin_model (.clk(clk), .rst(rst), .run(run), .pa_pin(pa_pin),
		.pc_pin(pc_pin));

	// ==========================================================
	// helpers
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(n < 50, "no ready");
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic sub_wr(input int p, input int k, input logic [7:0] d);
		apb(1, ba[p], {24'h0, sc[k]});
		apb(1, bc[p], {24'h0, d});
		m_sub[p][k] = d;
	endtask

	task automatic sub_chk(input int p, input int k);
		apb(1, ba[p], {24'h0, sc[k]});
		apb(0, bc[p], 0);
		chk(rd === {24'h0, m_sub[p][k]} && er === 1'b0, "sub-register readback");
	endtask

	function automatic logic [4:0] pa_exp(input int i, input logic [1:0] k);
		logic [3:0][4:0] t;
		case (i)
			0: t = {pamx_pkg::FN_TIMER_ZERO_OUTPUT_INV, pamx_pkg::FN_RSVD, pamx_pkg::FN_RSVD,
				pamx_pkg::FN_TIMER_ZERO_INPUT};
			1: t = {pamx_pkg::FN_ANALOG, pamx_pkg::FN_EXTERNAL_CLOCK_INPUT, pamx_pkg::FN_RSVD,
				pamx_pkg::FN_TIMER_ZERO_OUTPUT};
			2: t = {pamx_pkg::FN_RSVD, pamx_pkg::FN_TIMER_ONE_OUTPUT, pamx_pkg::FN_EXTERNAL_RESET,
				pamx_pkg::FN_SERIAL_DRIVER_ENABLE};
			3: t = {pamx_pkg::FN_ANALOG, pamx_pkg::FN_TIMER_ONE_INPUT,
				pamx_pkg::FN_COMPARATOR_RESULT_OUT, pamx_pkg::FN_SERIAL_CLEAR_TO_SEND};
			4: t = {pamx_pkg::FN_ANALOG, pamx_pkg::FN_RSVD, pamx_pkg::FN_RSVD,
				pamx_pkg::FN_SERIAL_RECEIVE_DATA};
			default: t = {pamx_pkg::FN_ANALOG, pamx_pkg::FN_RSVD,
				pamx_pkg::FN_TIMER_ONE_OUTPUT_INV, pamx_pkg::FN_SERIAL_TRANSMIT_DATA};
		endcase
		return t[k];
	endfunction

	function automatic logic [4:0] pc_exp(input int i, input logic b);
		if (i < 3) return b ? pamx_pkg::FN_ANALOG_OR_LED : pamx_pkg::FN_RSVD;
		if (i == 3) return b ? pamx_pkg::FN_LED_SINK : pamx_pkg::FN_COMPARATOR_RESULT_OUT;
		return b ? pamx_pkg::FN_LED_SINK : pamx_pkg::FN_RSVD;
	endfunction

	task automatic fn_chk();
		logic [4:0] e;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			e = m_sub[0][0][i] ? pa_exp(i, {m_sub[0][1][i], m_sub[0][2][i]}) : pamx_pkg::FN_GPIO;
			chk(pa_func[i] === e, "port A function");
		end
		for (int i = 0; i < 8; i++) begin
			e = m_sub[2][0][i] ? pc_exp(i, m_sub[2][1][i]) : pamx_pkg::FN_GPIO;
			chk(pc_func[i] === e, "port C function");
			chk(pc_led_en[i] === (e == pamx_pkg::FN_LED_SINK || e == pamx_pkg::FN_ANALOG_OR_LED),
				"led enable");
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// interrupt reference model
	always @(posedge clk) begin
		pwrite_d = psel && penable && pready && pwrite;
		if (rst) begin
			m_stat <= 0;
			m_en <= 0;
			m_pol <= 0;
		end else begin
			ev = 0;
			for (int i = 0; i < 6; i++) begin
				ev[i] = m_pol[i] ? (pa_pin[i] & ~pv_a[i]) : (~pa_pin[i] & pv_a[i]);
			end
			ev[15:8] = pc_pin ^ pv_c;
			ns = m_stat;
			if (pwrite_d && paddr == pamx_pkg::BA_INT_CLR) ns = ns & ~pwdata[15:0];
			if (pwrite_d && paddr == pamx_pkg::BA_INT_EN) m_en <= pwdata[15:0];
			if (pwrite_d && paddr == pamx_pkg::BA_EDGE_POL) m_pol <= pwdata[5:0];
			m_stat <= ns | ev;
		end
		pv_a <= pa_pin;
		pv_c <= pc_pin;
	end

	always @(negedge clk) begin
		if (irq_on) chk(irq === |(m_stat & m_en), "irq level");
	end

	// ==========================================================
	// tests
	initial begin
		{psel, penable, pwrite, run, irq_on} = 0;
		paddr = 0;
		pwdata = 0;
		rst = 1;
		foreach (m_sub[p, k]) m_sub[p][k] = 8'h00;
		m_sub[0][0] = pamx_pkg::RST_AF_A;
		void'($urandom(32'h18edb750));
		repeat (4) @(posedge clk);
		rst <= 0;
		foreach (m_sub[p, k]) sub_chk(p, k);
		fn_chk();
		for (int j = 0; j < 16; j++) begin
			for (int p = 0; p < 3; p++) begin
				sub_wr(p, 0, j < 4 ? 8'hff : 8'($urandom));
				sub_wr(p, 1, j < 4 ? {8{j[1]}} : 8'($urandom));
				sub_wr(p, 2, j < 4 ? {8{j[0]}} : 8'($urandom));
			end
			fn_chk();
			foreach (m_sub[p, k]) sub_chk(p, k);
		end
		apb(0, 14'h0000, 0);
		chk(er === 1'b1 && rd === 32'h0, "unmapped read");
		apb(1, pamx_pkg::BA_ADDR_C, 32'h01);
		apb(1, pamx_pkg::BA_CTL_C, 32'hff);
		apb(0, pamx_pkg::BA_CTL_C, 0);
		chk(rd === 32'h0 && er === 1'b0, "unused sub-register");
		for (int k = 0; k < 3; k++) sub_chk(2, k);
		irq_on = 1;
		for (int j = 0; j < 4; j++) begin
			v = 16'($urandom) & 16'hff3f;
			apb(1, pamx_pkg::BA_INT_EN, {16'h0, v});
			apb(1, pamx_pkg::BA_EDGE_POL, {26'h0, 6'($urandom)});
			run <= 1;
			repeat (25) @(posedge clk);
			apb(1, pamx_pkg::BA_INT_CLR, {16'h0, 16'($urandom)});
			repeat (10) @(posedge clk);
			run <= 0;
			apb(1, pamx_pkg::BA_INT_STAT, 32'hffff);
			apb(0, pamx_pkg::BA_INT_STAT, 0);
			chk(rd === {16'h0, m_stat}, "status");
			apb(0, pamx_pkg::BA_INT_EN, 0);
			chk(rd === {16'h0, v}, "enable readback");
			apb(0, pamx_pkg::BA_INT_CLR, 0);
			chk(rd === 32'h0, "clear reads zero");
		end
		apb(1, pamx_pkg::BA_INT_CLR, 32'hffff);
		apb(0, pamx_pkg::BA_INT_STAT, 0);
		chk(rd === 32'h0 && irq === 1'b0, "status cleared");
		wrap_up();
	end

	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
endmodule
